// ---- inc/mix_params.svh ----
// shared constants for the instruction slice execution unit
`ifndef MIX_PARAMS_SVH
`define MIX_PARAMS_SVH

// data byte constants
`define MIX_ZERO       8'h00
`define MIX_ONE        8'h01
`define MIX_BYTE_ONES  8'hFF

// field positions inside a data byte
`define MIX_SIGN       7
`define MIX_NIB_LO     3:0
`define MIX_NIB_HI     7:4

// field positions inside a program word
`define MIX_PW_LO      7:0
`define MIX_PW_HI      15:8

// program address limits
`define MIX_PADDR_MAX  16
`define MIX_PADDR_MIN  9
`define MIX_PADDR_DEF  11

`endif

// ---- inc/mix_pkg.sv ----
// types of the instruction slice execution unit
`include "mix_params.svh"
package mix_pkg;

   typedef enum logic [4:0] {
      OP_NOP              = 5'h00,
      OP_SKIP_DEC_TO_ACC  = 5'h01,
      OP_SET_BYTE         = 5'h02,
      OP_SET_BIT          = 5'h03,
      OP_SKIP_INC         = 5'h04,
      OP_SKIP_INC_TO_ACC  = 5'h05,
      OP_SKIP_BIT_SET     = 5'h06,
      OP_SKIP_ZERO        = 5'h07,
      OP_SKIP_ZERO_TO_ACC = 5'h08,
      OP_SKIP_BIT_CLEAR   = 5'h09,
      OP_SUB_MEM          = 5'h0A,
      OP_SUB_MEM_TO_MEM   = 5'h0B,
      OP_SUB_IMM          = 5'h0C,
      OP_SWAP             = 5'h0D,
      OP_SWAP_TO_ACC      = 5'h0E,
      OP_TBL_PAGED        = 5'h0F,
      OP_TBL_CURRENT      = 5'h10,
      OP_TBL_LAST         = 5'h11,
      OP_XOR_MEM          = 5'h12,
      OP_XOR_TO_MEM       = 5'h13,
      OP_XOR_IMM          = 5'h14
   } mix_op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_TBL   = 2'h1,
      ST_DUMMY = 2'h2
   } mix_st_t;

   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } mix_flags_t;

   typedef struct packed {
      mix_st_t                   st;
      logic                      busy;
      logic [7:0]                acc;
      mix_flags_t                fl;
      logic [7:0]                table_high_latch;
      logic                      mem_wr;
      logic [7:0]                mem_addr;
      logic [7:0]                mem_wdata;
      logic                      prog_rd;
      logic [`MIX_PADDR_MAX-1:0] prog_addr;
      logic                      skip;
      logic                      done;
   } mix_state_t;

endpackage

// ---- inc/mix_alu_if.sv ----
// carrier between the sequencer and its datapath
`timescale 1ns/1ps
interface mix_alu_if;
   import mix_pkg::*;
   mix_op_t    op;
   logic [7:0] acc;
   logic [7:0] mem;
   logic [7:0] imm;
   logic [2:0] bit_sel;
   logic [7:0] res;
   logic       to_acc;
   logic       to_mem;
   logic       upd_arith;
   logic       upd_z;
   mix_flags_t fl;
   logic       skip;
   logic       is_tbl;

   modport core (output op, acc, mem, imm, bit_sel,
                 input  res, to_acc, to_mem, upd_arith, upd_z, fl, skip, is_tbl);
   modport alu  (input  op, acc, mem, imm, bit_sel,
                 output res, to_acc, to_mem, upd_arith, upd_z, fl, skip, is_tbl);
endinterface

// ---- core/mix_alu.sv ----
// datapath: result, destination, flag updates and skip decision
`timescale 1ns/1ps
`include "mix_params.svh"
module mix_alu (
   mix_alu_if.alu bus
);
   import mix_pkg::*;

   function automatic logic is_zero(input logic [7:0] v);
      return v == `MIX_ZERO;
   endfunction

   // returns {c, ac, ov, diff}; carries read as not-borrow
   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] d;
      logic [4:0] n;
      logic       ov;
      d  = {1'b0, a} - {1'b0, b};
      n  = {1'b0, a[`MIX_NIB_LO]} - {1'b0, b[`MIX_NIB_LO]};
      ov = (a[`MIX_SIGN] != b[`MIX_SIGN]) && (d[`MIX_SIGN] != a[`MIX_SIGN]);
      return {~d[8], ~n[4], ov, d[7:0]};
   endfunction

   logic [7:0]  bmask;
   logic [10:0] s;

   always_comb begin
      bmask         = `MIX_ONE << bus.bit_sel;
      s             = sub8(bus.acc, (bus.op == OP_SUB_IMM) ? bus.imm : bus.mem);
      bus.res       = bus.mem;
      bus.to_acc    = 1'b0;
      bus.to_mem    = 1'b0;
      bus.upd_arith = 1'b0;
      bus.upd_z     = 1'b0;
      bus.skip      = 1'b0;
      bus.is_tbl    = 1'b0;
      case (bus.op)
         OP_SKIP_DEC_TO_ACC : begin
            bus.res    = bus.mem - `MIX_ONE;
            bus.to_acc = 1'b1;
            bus.skip   = is_zero(bus.res);
         end
         OP_SET_BYTE : begin
            bus.res    = `MIX_BYTE_ONES;
            bus.to_mem = 1'b1;
         end
         OP_SET_BIT : begin
            bus.res    = bus.mem | bmask;
            bus.to_mem = 1'b1;
         end
         OP_SKIP_INC : begin
            bus.res    = bus.mem + `MIX_ONE;
            bus.to_mem = 1'b1;
            bus.skip   = is_zero(bus.res);
         end
         OP_SKIP_INC_TO_ACC : begin
            bus.res    = bus.mem + `MIX_ONE;
            bus.to_acc = 1'b1;
            bus.skip   = is_zero(bus.res);
         end
         OP_SKIP_BIT_SET   : bus.skip = |(bus.mem & bmask);
         OP_SKIP_ZERO      : bus.skip = is_zero(bus.mem);
         OP_SKIP_ZERO_TO_ACC : begin
            bus.to_acc = 1'b1;
            bus.skip   = is_zero(bus.mem);
         end
         OP_SKIP_BIT_CLEAR : bus.skip = ~|(bus.mem & bmask);
         OP_SUB_MEM, OP_SUB_IMM, OP_SUB_MEM_TO_MEM : begin
            bus.res       = s[7:0];
            bus.to_acc    = (bus.op != OP_SUB_MEM_TO_MEM);
            bus.to_mem    = (bus.op == OP_SUB_MEM_TO_MEM);
            bus.upd_arith = 1'b1;
            bus.upd_z     = 1'b1;
         end
         OP_SWAP, OP_SWAP_TO_ACC : begin
            bus.res    = {bus.mem[`MIX_NIB_LO], bus.mem[`MIX_NIB_HI]};
            bus.to_acc = (bus.op == OP_SWAP_TO_ACC);
            bus.to_mem = (bus.op == OP_SWAP);
         end
         OP_TBL_PAGED, OP_TBL_CURRENT, OP_TBL_LAST : bus.is_tbl = 1'b1;
         OP_XOR_MEM, OP_XOR_TO_MEM, OP_XOR_IMM : begin
            bus.res    = bus.acc ^ ((bus.op == OP_XOR_IMM) ? bus.imm : bus.mem);
            bus.to_acc = (bus.op != OP_XOR_TO_MEM);
            bus.to_mem = (bus.op == OP_XOR_TO_MEM);
            bus.upd_z  = 1'b1;
         end
         default : bus.res = bus.mem;
      endcase
      bus.fl.c  = s[10];
      bus.fl.ac = s[9];
      bus.fl.ov = s[8];
      bus.fl.z  = is_zero(bus.res);
   end

endmodule

// ---- core/mix_core.sv ----
// execution unit for skip, set, subtract, swap, xor and table read instructions
//
// Summary of operation
// - decrement to accumulator, data byte kept, skip on zero, flags kept
// - whole-byte set writes all ones, flags kept
// - bit set forces one selected bit, rest and flags kept
// - increment data byte in place, skip if new value zero, flags kept
// - increment into accumulator, data byte kept, skip on zero, flags kept
// - a taken skip adds one dummy cycle, otherwise continue normally
// - skip when selected bit is one, nothing modified
// - skip when whole data byte is zero, nothing modified
// - copy data byte to accumulator, skip if it is zero, flags kept
// - skip when selected bit is zero, nothing modified
// - accumulator minus byte into accumulator, carry is not-borrow
// - accumulator minus byte into the data byte, same flags
// - accumulator minus immediate into accumulator, same flags
// - swap nibbles of the data byte in place, flags kept
// - swapped data byte into accumulator, data byte and flags kept
// - table read at both pointer bytes: low to memory, high to latch
// - table read in current page at low pointer offset
// - table read in last page at low pointer offset
// - xor accumulator with byte into accumulator, zero flag only
// - xor accumulator with byte into the data byte, zero flag only
// - xor accumulator with immediate into accumulator, zero flag only
`timescale 1ns/1ps
`include "mix_params.svh"
module mix_core #(
   parameter int PADDR_W = `MIX_PADDR_DEF
) (
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             start_i,
   input  wire mix_pkg::mix_op_t op_i,
   input  wire logic [7:0]       mem_addr_i,
   input  wire logic [7:0]       mem_data_i,
   input  wire logic [7:0]       imm_i,
   input  wire logic [2:0]       bit_sel_i,
   input  wire logic [7:0]       table_pointer_low_i,
   input  wire logic [7:0]       table_pointer_high_i,
   input  wire logic [7:0]       cur_page_i,
   input  wire logic [15:0]      prog_data_i,
   output logic                  busy_o,
   output logic                  done_o,
   output logic                  skip_o,
   output logic [7:0]            acc_o,
   output logic                  signed_range_flag_o,
   output logic                  zero_flag_o,
   output logic                  nibble_carry_flag_o,
   output logic                  carry_flag_o,
   output logic                  mem_wr_o,
   output logic [7:0]            mem_addr_o,
   output logic [7:0]            mem_wdata_o,
   output logic                  prog_rd_o,
   output logic [PADDR_W-1:0]    prog_addr_o,
   output logic [7:0]            table_high_latch_o
);
   import mix_pkg::*;

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   // the page field must exist and the address must fit the state word
   if (PADDR_W < `MIX_PADDR_MIN || PADDR_W > `MIX_PADDR_MAX) begin : g_bad_width
      $error("PADDR_W out of range");
   end

   // ------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------
   mix_state_t                state;
   mix_state_t                next_state;
   logic [`MIX_PADDR_MAX-1:0] next_taddr;

   mix_alu_if alu_bus();

   assign alu_bus.op      = op_i;
   assign alu_bus.acc     = state.acc;
   assign alu_bus.mem     = mem_data_i;
   assign alu_bus.imm     = imm_i;
   assign alu_bus.bit_sel = bit_sel_i;

   mix_alu u_alu (
      .bus (alu_bus)
   );

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      next_taddr = '0;
      case (op_i)
         OP_TBL_PAGED   : next_taddr = {table_pointer_high_i, table_pointer_low_i};
         OP_TBL_CURRENT : next_taddr = {cur_page_i, table_pointer_low_i};
         // all-ones page bits select the last page whatever the width
         OP_TBL_LAST    : next_taddr = {`MIX_BYTE_ONES, table_pointer_low_i};
         default        : next_taddr = '0;
      endcase

      next_state         = state;
      next_state.mem_wr  = 1'b0;
      next_state.prog_rd = 1'b0;
      next_state.skip    = 1'b0;
      next_state.done    = 1'b0;
      case (state.st)
         ST_IDLE : begin
            // a start while busy is simply not seen here
            if (start_i) begin
               next_state.mem_addr = mem_addr_i;
               if (alu_bus.is_tbl) begin
                  next_state.prog_rd   = 1'b1;
                  next_state.prog_addr = next_taddr;
                  next_state.st        = ST_TBL;
                  next_state.busy      = 1'b1;
               end else begin
                  if (alu_bus.to_acc) begin
                     next_state.acc = alu_bus.res;
                  end
                  next_state.mem_wr    = alu_bus.to_mem;
                  next_state.mem_wdata = alu_bus.res;
                  if (alu_bus.upd_arith) begin
                     next_state.fl.c  = alu_bus.fl.c;
                     next_state.fl.ac = alu_bus.fl.ac;
                     next_state.fl.ov = alu_bus.fl.ov;
                  end
                  if (alu_bus.upd_z) begin
                     next_state.fl.z = alu_bus.fl.z;
                  end
                  if (alu_bus.skip) begin
                     next_state.st   = ST_DUMMY;
                     next_state.skip = 1'b1;
                     next_state.busy = 1'b1;
                  end else begin
                     next_state.done = 1'b1;
                  end
               end
            end
         end
         ST_TBL : begin
            // program word must be valid while prog_rd_o is high
            next_state.mem_wr    = 1'b1;
            next_state.mem_wdata = prog_data_i[`MIX_PW_LO];
            next_state.table_high_latch      = prog_data_i[`MIX_PW_HI];
            next_state.done      = 1'b1;
            next_state.busy      = 1'b0;
            next_state.st        = ST_IDLE;
         end
         ST_DUMMY : begin
            next_state.done = 1'b1;
            next_state.busy = 1'b0;
            next_state.st   = ST_IDLE;
         end
         default : begin
            next_state.busy = 1'b0;
            next_state.st   = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign busy_o              = state.busy;
   assign done_o              = state.done;
   assign skip_o              = state.skip;
   assign acc_o               = state.acc;
   assign signed_range_flag_o = state.fl.ov;
   assign zero_flag_o         = state.fl.z;
   assign nibble_carry_flag_o = state.fl.ac;
   assign carry_flag_o        = state.fl.c;
   assign mem_wr_o            = state.mem_wr;
   assign mem_addr_o          = state.mem_addr;
   assign mem_wdata_o         = state.mem_wdata;
   assign prog_rd_o           = state.prog_rd;
   assign prog_addr_o         = state.prog_addr[PADDR_W-1:0];
   assign table_high_latch_o  = state.table_high_latch;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   logic take;
   assign take = start_i && !busy_o;

   sequence s_take(mix_op_t o);
      take && (op_i == o);
   endsequence

   sequence s_skip_then_done;
      skip_o && busy_o && !done_o ##1 done_o && !skip_o && !busy_o;
   endsequence

   sequence s_flags_kept;
      $stable(carry_flag_o) && $stable(zero_flag_o)
         && $stable(nibble_carry_flag_o) && $stable(signed_range_flag_o);
   endsequence

   AST_DEC_TO_ACC: assert property (
      s_take(OP_SKIP_DEC_TO_ACC) |=> (acc_o == $past(mem_data_i) - `MIX_ONE)
         && !mem_wr_o && s_flags_kept)
      else $error("decrement to accumulator wrong");

   AST_SET_BYTE: assert property (
      s_take(OP_SET_BYTE) |=> mem_wr_o && (mem_wdata_o == `MIX_BYTE_ONES)
         && (mem_addr_o == $past(mem_addr_i)) && s_flags_kept)
      else $error("byte set wrong");

   AST_SET_BIT: assert property (
      s_take(OP_SET_BIT) |=> mem_wr_o
         && (mem_wdata_o == ($past(mem_data_i) | (`MIX_ONE << $past(bit_sel_i)))))
      else $error("bit set wrong");

   AST_INC_MEM: assert property (
      s_take(OP_SKIP_INC) |=> mem_wr_o && (mem_wdata_o == $past(mem_data_i) + `MIX_ONE)
         && (skip_o == (mem_wdata_o == `MIX_ZERO)) && $stable(acc_o))
      else $error("increment in place wrong");

   AST_INC_TO_ACC: assert property (
      s_take(OP_SKIP_INC_TO_ACC) |=> !mem_wr_o && (acc_o == $past(mem_data_i) + `MIX_ONE)
         && (skip_o == (acc_o == `MIX_ZERO)))
      else $error("increment to accumulator wrong");

   AST_SKIP_TWO_CYCLES: assert property (
      take && !alu_bus.is_tbl && alu_bus.skip |=> s_skip_then_done)
      else $error("skip did not take two cycles");

   AST_NO_SKIP_ONE_CYCLE: assert property (
      take && !alu_bus.is_tbl && !alu_bus.skip |=> done_o && !skip_o && !busy_o)
      else $error("plain instruction not done in one cycle");

   AST_BIT_TESTS: assert property (
      (s_take(OP_SKIP_BIT_SET) or s_take(OP_SKIP_BIT_CLEAR)) |=> !mem_wr_o
         && $stable(acc_o) && (skip_o == ($past(mem_data_i[bit_sel_i])
         == ($past(op_i) == OP_SKIP_BIT_SET))))
      else $error("bit test skip wrong");

   AST_ZERO_TESTS: assert property (
      (s_take(OP_SKIP_ZERO) or s_take(OP_SKIP_ZERO_TO_ACC)) |=> !mem_wr_o
         && (skip_o == ($past(mem_data_i) == `MIX_ZERO)) && s_flags_kept)
      else $error("zero test skip wrong");

   AST_SUB_FLAGS: assert property (
      (s_take(OP_SUB_MEM) or s_take(OP_SUB_IMM)) |=>
         (carry_flag_o == ($past(acc_o) >= (($past(op_i) == OP_SUB_IMM)
         ? $past(imm_i) : $past(mem_data_i))))
         && (zero_flag_o == (acc_o == `MIX_ZERO)))
      else $error("subtract flags wrong");

   AST_SUB_TO_MEM: assert property (
      s_take(OP_SUB_MEM_TO_MEM) |=> mem_wr_o && $stable(acc_o)
         && (mem_wdata_o == $past(acc_o) - $past(mem_data_i)))
      else $error("subtract to memory wrong");

   AST_SWAP: assert property (
      (s_take(OP_SWAP) or s_take(OP_SWAP_TO_ACC)) |=>
         ({mem_wdata_o[`MIX_NIB_LO], mem_wdata_o[`MIX_NIB_HI]} == $past(mem_data_i))
         && (mem_wr_o == ($past(op_i) == OP_SWAP)) && s_flags_kept)
      else $error("nibble swap wrong");

   AST_TBL_PAGED: assert property (
      s_take(OP_TBL_PAGED) |=> prog_rd_o && busy_o
         && (prog_addr_o == PADDR_W'({$past(table_pointer_high_i),
         $past(table_pointer_low_i)}))
         ##1 mem_wr_o && done_o && (mem_wdata_o == $past(prog_data_i[`MIX_PW_LO]))
         && (table_high_latch_o == $past(prog_data_i[`MIX_PW_HI])) && s_flags_kept)
      else $error("paged table read wrong");

   AST_TBL_LAST: assert property (
      s_take(OP_TBL_LAST) |=> prog_rd_o
         && (prog_addr_o == PADDR_W'({`MIX_BYTE_ONES, $past(table_pointer_low_i)})))
      else $error("last page table address wrong");

   AST_XOR_Z_ONLY: assert property (
      s_take(OP_XOR_MEM) |=> (acc_o == ($past(acc_o) ^ $past(mem_data_i)))
         && (zero_flag_o == (acc_o == `MIX_ZERO)) && $stable(carry_flag_o)
         && $stable(nibble_carry_flag_o) && $stable(signed_range_flag_o))
      else $error("xor result or flags wrong");

endmodule

// ---- test/mix_mem_model.sv ----
// program and data memory seen by the execution unit
`timescale 1ns/1ps
module mix_mem_model #(
   parameter int PADDR_W = 11
) (
   input  wire logic               core_clk_i,
   input  wire logic [7:0]         rd_addr_i,
   output logic      [7:0]         rd_data_o,
   input  wire logic               mem_wr_i,
   input  wire logic [7:0]         mem_addr_i,
   input  wire logic [7:0]         mem_wdata_i,
   input  wire logic               prog_rd_i,
   input  wire logic [PADDR_W-1:0] prog_addr_i,
   output logic      [15:0]        prog_data_o
);
   logic [7:0]  mem [256];
   logic [15:0] last = 16'h0000;
   logic [15:0] word;

   always @(posedge core_clk_i) begin
      if (mem_wr_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
      if (prog_rd_i) begin
         last <= word;
      end
   end

   assign rd_data_o = mem[rd_addr_i];
   // word encodes its page in the high byte so a wrong page shows up
   assign word = {8'hA0 ^ 8'(prog_addr_i >> 8), 8'(prog_addr_i) ^ 8'h3C};
   // released bus never holds the old word
   assign prog_data_o = prog_rd_i ? word : ~last;
endmodule

// ---- test/tb_mix_core.sv ----
// self-checking bench for the instruction slice execution unit
`timescale 1ns/1ps
module tb_mix_core;
   import mix_pkg::*;
   logic                core_clk_i = 1'h0;
   logic                sys_rst_i = 1'h1;
   logic                start_i = 1'h0;
   mix_op_t             op_i = OP_NOP;
   logic [7:0]          mem_addr_i = 8'h00;
   logic [7:0]          mem_data_i;
   logic [7:0]          imm_i = 8'h00;
   logic [2:0]          bit_sel_i = 3'h0;
   logic [7:0]          table_pointer_low_i = 8'h11;
   logic [7:0]          table_pointer_high_i = 8'h05;
   logic [7:0]          cur_page_i = 8'h02;
   logic [15:0]         prog_data_i;
   logic                busy_o, done_o, skip_o, mem_wr_o, prog_rd_o;
   logic [7:0]          acc_o, mem_addr_o, mem_wdata_o, table_high_latch_o;
   logic                signed_range_flag_o, zero_flag_o, nibble_carry_flag_o, carry_flag_o;
   logic [10:0]         prog_addr_o;
   int                  err_count = 0;
   int                  check_count = 0;

   mix_core #(.PADDR_W(11)) mix_core_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .start_i(start_i), .op_i(op_i), .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i),
      .imm_i(imm_i), .bit_sel_i(bit_sel_i), .table_pointer_low_i(table_pointer_low_i),
      .table_pointer_high_i(table_pointer_high_i), .cur_page_i(cur_page_i),
      .prog_data_i(prog_data_i), .busy_o(busy_o), .done_o(done_o), .skip_o(skip_o),
      .acc_o(acc_o), .signed_range_flag_o(signed_range_flag_o), .zero_flag_o(zero_flag_o),
      .nibble_carry_flag_o(nibble_carry_flag_o), .carry_flag_o(carry_flag_o),
      .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
      .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
      .table_high_latch_o(table_high_latch_o));

   mix_mem_model #(.PADDR_W(11)) mix_mem_model_inst (.core_clk_i(core_clk_i),
      .rd_addr_i(mem_addr_i), .rd_data_o(mem_data_i), .mem_wr_i(mem_wr_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .prog_rd_i(prog_rd_o),
      .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i));

   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end

   // ------------------------------------------------------------
   // compare, run one instruction, close
   // ------------------------------------------------------------
   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic c(input mix_op_t op, input logic [7:0] a, m, x, input logic [2:0] b,
                    input logic [7:0] eacc, emem, input logic esk, input logic [3:0] efl);
      int   n;
      logic sk;
      logic tbl;
      tbl = op inside {OP_TBL_PAGED, OP_TBL_CURRENT, OP_TBL_LAST};
      mix_mem_model_inst.mem[a] = m;
      @(posedge core_clk_i);
      op_i <= op;
      mem_addr_i <= a;
      imm_i <= x;
      bit_sel_i <= b;
      start_i <= 1'h1;
      @(posedge core_clk_i);
      start_i <= 1'h0;
      n = 0;
      sk = 1'h0;
      #1;
      while (done_o !== 1'h1 && n < 4) begin
         sk = sk | (skip_o === 1'h1);
         @(posedge core_clk_i);
         #1;
         n++;
      end
      // let the final memory write land before reading it back
      @(posedge core_clk_i);
      #1;
      ck(8'(n), (esk || tbl) ? 8'h01 : 8'h00);
      ck({7'h00, sk}, {7'h00, esk});
      ck(acc_o, eacc);
      ck(mix_mem_model_inst.mem[a], emem);
      ck({4'h0, signed_range_flag_o, zero_flag_o, nibble_carry_flag_o, carry_flag_o},
         {4'h0, efl});
      $display("test %s ended", op.name());
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      results();
   end

   // ------------------------------------------------------------
   // instruction sequence; acc and flags carry from case to case
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'h0;
      c(OP_SET_BYTE,         8'h01, 8'h12, 8'h00, 3'h0, 8'h00, 8'hFF, 1'h0, 4'h0);
      c(OP_SET_BIT,          8'h02, 8'h41, 8'h00, 3'h5, 8'h00, 8'h61, 1'h0, 4'h0);
      c(OP_SET_BIT,          8'h03, 8'h00, 8'h00, 3'h7, 8'h00, 8'h80, 1'h0, 4'h0);
      c(OP_SKIP_DEC_TO_ACC,  8'h04, 8'h01, 8'h00, 3'h0, 8'h00, 8'h01, 1'h1, 4'h0);
      c(OP_SKIP_DEC_TO_ACC,  8'h04, 8'h00, 8'h00, 3'h0, 8'hFF, 8'h00, 1'h0, 4'h0);
      c(OP_SKIP_INC,         8'h05, 8'hFF, 8'h00, 3'h0, 8'hFF, 8'h00, 1'h1, 4'h0);
      c(OP_SKIP_INC,         8'h05, 8'h7F, 8'h00, 3'h0, 8'hFF, 8'h80, 1'h0, 4'h0);
      c(OP_SKIP_INC_TO_ACC,  8'h06, 8'hFF, 8'h00, 3'h0, 8'h00, 8'hFF, 1'h1, 4'h0);
      c(OP_SKIP_INC_TO_ACC,  8'h06, 8'h41, 8'h00, 3'h0, 8'h42, 8'h41, 1'h0, 4'h0);
      c(OP_SKIP_BIT_SET,     8'h07, 8'h08, 8'h00, 3'h3, 8'h42, 8'h08, 1'h1, 4'h0);
      c(OP_SKIP_BIT_SET,     8'h07, 8'h08, 8'h00, 3'h2, 8'h42, 8'h08, 1'h0, 4'h0);
      c(OP_SKIP_BIT_CLEAR,   8'h07, 8'hF7, 8'h00, 3'h3, 8'h42, 8'hF7, 1'h1, 4'h0);
      c(OP_SKIP_BIT_CLEAR,   8'h07, 8'hF7, 8'h00, 3'h0, 8'h42, 8'hF7, 1'h0, 4'h0);
      c(OP_SKIP_ZERO,        8'h08, 8'h00, 8'h00, 3'h0, 8'h42, 8'h00, 1'h1, 4'h0);
      c(OP_SKIP_ZERO,        8'h08, 8'h01, 8'h00, 3'h0, 8'h42, 8'h01, 1'h0, 4'h0);
      c(OP_SKIP_ZERO_TO_ACC, 8'h09, 8'h00, 8'h00, 3'h0, 8'h00, 8'h00, 1'h1, 4'h0);
      c(OP_SKIP_ZERO_TO_ACC, 8'h09, 8'h10, 8'h00, 3'h0, 8'h10, 8'h10, 1'h0, 4'h0);
      c(OP_SUB_MEM,          8'h0A, 8'h20, 8'h00, 3'h0, 8'hF0, 8'h20, 1'h0, 4'h2);
      c(OP_SUB_MEM,          8'h0A, 8'h71, 8'h00, 3'h0, 8'h7F, 8'h71, 1'h0, 4'h9);
      c(OP_SUB_MEM_TO_MEM,   8'h0B, 8'h7F, 8'h00, 3'h0, 8'h7F, 8'h00, 1'h0, 4'h7);
      c(OP_SUB_IMM,          8'h0C, 8'h00, 8'h80, 3'h0, 8'hFF, 8'h00, 1'h0, 4'hA);
      c(OP_SWAP,             8'h0C, 8'h3C, 8'h00, 3'h0, 8'hFF, 8'hC3, 1'h0, 4'hA);
      c(OP_SWAP_TO_ACC,      8'h0D, 8'h5A, 8'h00, 3'h0, 8'hA5, 8'h5A, 1'h0, 4'hA);
      c(OP_XOR_MEM,          8'h0E, 8'hA5, 8'h00, 3'h0, 8'h00, 8'hA5, 1'h0, 4'hE);
      c(OP_XOR_TO_MEM,       8'h0F, 8'h3C, 8'h00, 3'h0, 8'h00, 8'h3C, 1'h0, 4'hA);
      c(OP_XOR_IMM,          8'h0F, 8'h3C, 8'h66, 3'h0, 8'h66, 8'h3C, 1'h0, 4'hA);
      c(OP_XOR_IMM,          8'h0F, 8'h3C, 8'h66, 3'h0, 8'h00, 8'h3C, 1'h0, 4'hE);
      c(OP_NOP,              8'h0F, 8'h3C, 8'h00, 3'h0, 8'h00, 8'h3C, 1'h0, 4'hE);
      c(OP_TBL_PAGED,        8'h10, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2D, 1'h0, 4'hE);
      ck(table_high_latch_o, 8'hA5);
      c(OP_TBL_CURRENT,      8'h11, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2D, 1'h0, 4'hE);
      ck(table_high_latch_o, 8'hA2);
      c(OP_TBL_LAST,         8'h12, 8'h00, 8'h00, 3'h0, 8'h00, 8'h2D, 1'h0, 4'hE);
      ck(table_high_latch_o, 8'hA7);
      results();
   end
endmodule
